// ==== logic/sio_cfg_defines.vh ====
`ifndef SIO_CFG_DEFINES_VH
`define SIO_CFG_DEFINES_VH
// --------------------------------------------------------------------------
// Host port addresses and unlock keys.
// --------------------------------------------------------------------------
`define SIO_CFG_PORT_PRI 11'h3F0
`define SIO_CFG_PORT_SEC 11'h370
`define SIO_KEY_ENTER 8'h44
`define SIO_KEY_EXIT 8'hAA
// --------------------------------------------------------------------------
// Register indices.
// --------------------------------------------------------------------------
`define SIO_IDX_EXTSETUP 8'h04
`define SIO_IDX_ADDRSETUP 8'h05
`define SIO_IDX_DRVTYPES 8'h06
`define SIO_IDX_PWRBOOT 8'h07
`define SIO_IDX_AUXLO 8'h08
`define SIO_IDX_AUXHI 8'h09
`define SIO_IDX_PFIFOTHR 8'h0A
`define SIO_IDX_RATETBL 8'h0B
`define SIO_IDX_SERMODE 8'h0C
`define SIO_IDX_DEVID 8'h0D
`define SIO_IDX_REVID 8'h0E
`define SIO_IDX_TEST 8'h0F
// --------------------------------------------------------------------------
// Reset values.
// --------------------------------------------------------------------------
`define SIO_RST_ZERO 8'h00
`define SIO_RST_DRVTYPES 8'hFF
`define SIO_RST_RATETBL 8'h00
`define SIO_RST_SERMODE 8'h00
// --------------------------------------------------------------------------
// Field positions.
// --------------------------------------------------------------------------
`define SIO_B_FDC_SEC 0
`define SIO_B_IDE_SEC 1
`define SIO_B_NONBURST 2
`define SIO_B_SWAP 5
`define SIO_B_EXTDEC 6
`define SIO_B_APD_FDC 7
`define SIO_B_APD_PAR 4
`define SIO_B_MID1_INV 3
`define SIO_B_MID2_INV 2
`define SIO_F_BOOT 1:0
`define SIO_F_AUXHI 2:0
`define SIO_B_ECP_MODE 1
`define SIO_B_EPP_MODE 0
`define SIO_B_MIDI1 4
`define SIO_B_MIDI2 5
`define SIO_B_HS2 7
`define SIO_B_HS1 6
`define SIO_F_U2MODE 5:3
`define SIO_B_HALFDUP 2
`define SIO_B_TXINV 1
`define SIO_B_RXINV 0
// --------------------------------------------------------------------------
// Modes and timing.
// --------------------------------------------------------------------------
`define SIO_U2_STD 3'h0
`define SIO_U2_IRDA 3'h1
`define SIO_U2_ASK 3'h2
`define SIO_ECR_EPP 3'h4
`define SIO_ECR_SPP 3'h0
`define SIO_MIDI_PRE 12
`define SIO_MIDI_POST 16
`define SIO_MIDI_PRE_LAST 4'hB
`define SIO_MIDI_POST_LAST 4'hF
`define SIO_ECR_W 3
`endif

// ==== logic/sio_cfg_bank.v ====
// Operation
// RULE_01: Index 06H holds four drive-type codes, FFH after reset.
// RULE_02: Index 05H bit 0 moves floppy decode from 3F0-3F7 to 370-377.
// RULE_03: Index 05H bit 1 moves disk decode to the secondary port group.
// RULE_04: Index 05H bit 2 set makes floppy DMA request and interrupt pulse per byte.
// RULE_05: Index 05H bit 5 swaps drive and motor selects of units 0 and 1.
// RULE_06: Index 05H bit 6 selects encoded outputs for an external two-to-four decoder.
// RULE_07: Index 07H bits 7..4 enable auto powerdown per unit; reset 00H.
// RULE_08: Index 07H bits 3 and 2 invert media-ID 1 and 2 inputs.
// RULE_09: Index 07H bits 1:0 give boot drive A to D.
// RULE_10: Aux decode compares 11 address bits from 08H and 09H, qualified by AEN low.
// RULE_11: Without extended-capabilities parallel mode, aux decode treats address bit 10 as zero.
// RULE_12: Index 0AH is the extended parallel FIFO threshold, reset 00H.
// RULE_13: Rate table register gives two bits per drive, drive 0 lowest.
// RULE_14: Serial control bits 7 and 6 enable high speed on ports 2 and 1.
// RULE_15: Serial control bits 5:3 select port 2 standard, IrDA or ASK infrared.
// RULE_16: Serial control bit 2 selects half duplex for serial port 2.
// RULE_17: Serial control bits 1 and 0 make port 2 transmit and receive active low.
// RULE_18: Index 0DH returns a fixed identification byte; writes ignored.
// RULE_19: Index 0EH returns a fixed revision byte.
// RULE_20: Host keeps test register 0FH at zero; reset value 00H.
// RULE_21: With both extended modes, control code 100 picks enhanced, 000 standard.
// RULE_22: Serial MIDI clock divides the 24 MHz reference by 12 then 16.
// RULE_23: Host writes 44H twice to enter, AAH to leave configuration mode.
// RULE_24: Any other write between the two unlock writes cancels entry.
// RULE_25: Data port is ignored outside configuration mode; select index chooses register.
`timescale 1ns/10ps
`default_nettype none
`include "sio_cfg_defines.vh"
module sio_cfg_bank #(
	parameter [7:0] DEV_ID = 8'h5A,
	parameter [7:0] REV_ID = 8'h01,
	parameter integer ADDR_W = 11
) (
	input wire clk,
	input wire nrst,
	input wire [ADDR_W-1:0] ioAddr,
	input wire [7:0] ioDataIn,
	input wire ioWrN,
	input wire ioRdN,
	input wire aen,
	input wire cfgAtSecondary,
	input wire [2:0] ecrMode,
	input wire fdcDmaReqIn,
	input wire fdcIrqIn,
	input wire fdcByteDone,
	input wire [3:0] driveSelIn,
	input wire [3:0] motorSelIn,
	input wire mediaId1In,
	input wire mediaId2In,
	input wire [1:0] rateDrive,
	input wire serial2TxIn,
	input wire receiveInput,
	output reg [7:0] ioDataOut_ff,
	output reg ioDataOe_ff,
	output reg cfgMode_ff,
	output reg fdcAtSecondary_ff,
	output reg ideAtSecondary_ff,
	output reg nonBurstDma_ff,
	output reg floppyDmaRequest_ff,
	output reg floppyInterruptRequest_ff,
	output reg [3:0] driveSel_ff,
	output reg [3:0] motorSel_ff,
	output reg externalDriveDecoderSel_ff,
	output reg [1:0] densityMode_ff,
	output reg [15:0] driveTypes_ff,
	output reg [3:0] autoPowerdownEn_ff,
	output reg mediaId1_ff,
	output reg mediaId2_ff,
	output reg [1:0] bootDrive_ff,
	output reg auxAddressDecode_ff,
	output reg [7:0] parFifoThreshold_ff,
	output reg [1:0] rateTableHighBit_ff,
	output reg [1:0] rateTableLowBit_ff,
	output reg [1:0] uartHighSpeed_ff,
	output reg infraredPulseMode_ff,
	output reg infraredCarrierMode_ff,
	output reg serial2HalfDuplex_ff,
	output reg transmitOutput_ff,
	output reg serial2Rx_ff,
	output reg eppViaEcr_ff,
	output reg midiBaudTick_ff
);
// --------------------------------------------------------------------------
// Bus synchronisers. Strobes come from the host bus, so every bus pin is
// resynchronised; write and read are acted on at their falling edge.
// --------------------------------------------------------------------------
reg [ADDR_W-1:0] addrS1_ff;
reg [ADDR_W-1:0] addrS2_ff;
reg [7:0] dataS1_ff;
reg [7:0] dataS2_ff;
reg [3:0] ctlS1_ff;
reg [3:0] ctlS2_ff;
reg wrPrev_ff;
reg rdPrev_ff;
reg [1:0] midS1_ff;
reg [1:0] midS2_ff;
wire wrStrobe = wrPrev_ff & ~ctlS2_ff[0];
wire rdStrobe = rdPrev_ff & ~ctlS2_ff[1];
wire aenS = ctlS2_ff[2];
wire [ADDR_W-1:0] cfgPort = ctlS2_ff[3] ? `SIO_CFG_PORT_SEC : `SIO_CFG_PORT_PRI;
wire hitSel = ~aenS & (addrS2_ff == cfgPort);
wire hitData = ~aenS & (addrS2_ff == cfgPort + 1'b1);
always @(posedge clk or negedge nrst) begin
	if (!nrst) begin
		addrS1_ff <= {ADDR_W{1'b0}};
		addrS2_ff <= {ADDR_W{1'b0}};
		dataS1_ff <= 8'h00;
		dataS2_ff <= 8'h00;
		ctlS1_ff <= 4'h3;
		ctlS2_ff <= 4'h3;
		wrPrev_ff <= 1'b1;
		rdPrev_ff <= 1'b1;
		midS1_ff <= 2'h0;
		midS2_ff <= 2'h0;
	end else begin
		addrS1_ff <= ioAddr;
		addrS2_ff <= addrS1_ff;
		dataS1_ff <= ioDataIn;
		dataS2_ff <= dataS1_ff;
		ctlS1_ff <= {cfgAtSecondary, aen, ioRdN, ioWrN};
		ctlS2_ff <= ctlS1_ff;
		wrPrev_ff <= ctlS2_ff[0];
		rdPrev_ff <= ctlS2_ff[1];
		midS1_ff <= {mediaId2In, mediaId1In};
		midS2_ff <= midS1_ff;
	end
end
// --------------------------------------------------------------------------
// Unlock sequence. Any write other than a key write to the select port
// disarms the first key, so an interleaved write cancels entry.
// --------------------------------------------------------------------------
reg keyArmed_ff;
reg [7:0] selIndex_ff;
always @(posedge clk or negedge nrst) begin
	if (!nrst) begin
		keyArmed_ff <= 1'b0;
		cfgMode_ff <= 1'b0;
		selIndex_ff <= 8'h00;
	end else if (wrStrobe) begin
		keyArmed_ff <= 1'b0; // RULE_24
		if (hitSel && !cfgMode_ff && dataS2_ff == `SIO_KEY_ENTER) begin
			keyArmed_ff <= ~keyArmed_ff; // RULE_23
			cfgMode_ff <= keyArmed_ff; // RULE_23
		end else if (hitSel && cfgMode_ff && dataS2_ff == `SIO_KEY_EXIT)
			cfgMode_ff <= 1'b0; // RULE_23
		else if (hitSel && cfgMode_ff)
			selIndex_ff <= dataS2_ff; // RULE_25
	end
end
// --------------------------------------------------------------------------
// Indexed registers.
// --------------------------------------------------------------------------
reg [7:0] extSetup_ff;
reg [7:0] addrSetup_ff;
reg [7:0] pwrBoot_ff;
reg [7:0] auxLo_ff;
reg [7:0] auxHi_ff;
reg [7:0] rateTbl_ff;
reg [7:0] serMode_ff;
reg [7:0] test_ff;
wire cfgWr = wrStrobe & hitData & cfgMode_ff; // RULE_25
always @(posedge clk or negedge nrst) begin
	if (!nrst) begin
		extSetup_ff <= `SIO_RST_ZERO;
		addrSetup_ff <= `SIO_RST_ZERO;
		driveTypes_ff <= {`SIO_RST_DRVTYPES, `SIO_RST_DRVTYPES}; // RULE_01
		pwrBoot_ff <= `SIO_RST_ZERO; // RULE_07
		auxLo_ff <= `SIO_RST_ZERO;
		auxHi_ff <= `SIO_RST_ZERO;
		parFifoThreshold_ff <= `SIO_RST_ZERO; // RULE_12
		rateTbl_ff <= `SIO_RST_RATETBL;
		serMode_ff <= `SIO_RST_SERMODE;
		test_ff <= `SIO_RST_ZERO; // RULE_20
	end else if (cfgWr) begin
		case (selIndex_ff)
			`SIO_IDX_EXTSETUP: extSetup_ff <= {1'b0, dataS2_ff[6:0]};
			`SIO_IDX_ADDRSETUP: addrSetup_ff <= {1'b0, dataS2_ff[6:0]};
			`SIO_IDX_DRVTYPES: driveTypes_ff <= {dataS2_ff, dataS2_ff}; // RULE_01
			`SIO_IDX_PWRBOOT: pwrBoot_ff <= dataS2_ff;
			`SIO_IDX_AUXLO: auxLo_ff <= dataS2_ff;
			`SIO_IDX_AUXHI: auxHi_ff <= {5'h00, dataS2_ff[2:0]};
			`SIO_IDX_PFIFOTHR: parFifoThreshold_ff <= dataS2_ff; // RULE_12
			`SIO_IDX_RATETBL: rateTbl_ff <= dataS2_ff;
			`SIO_IDX_SERMODE: serMode_ff <= dataS2_ff;
			`SIO_IDX_TEST: test_ff <= dataS2_ff;
			default: test_ff <= test_ff; // RULE_18
		endcase
	end
end
// Drive-type byte is mirrored so the upper half tracks software too.
// --------------------------------------------------------------------------
// Read path. The data bus is driven only for one read of the data port.
// --------------------------------------------------------------------------
function [7:0] rd_mux;
	input [7:0] idx;
	begin
		case (idx)
			`SIO_IDX_EXTSETUP: rd_mux = extSetup_ff;
			`SIO_IDX_ADDRSETUP: rd_mux = addrSetup_ff;
			`SIO_IDX_DRVTYPES: rd_mux = driveTypes_ff[7:0];
			`SIO_IDX_PWRBOOT: rd_mux = pwrBoot_ff;
			`SIO_IDX_AUXLO: rd_mux = auxLo_ff;
			`SIO_IDX_AUXHI: rd_mux = auxHi_ff;
			`SIO_IDX_PFIFOTHR: rd_mux = parFifoThreshold_ff;
			`SIO_IDX_RATETBL: rd_mux = rateTbl_ff;
			`SIO_IDX_SERMODE: rd_mux = serMode_ff;
			`SIO_IDX_DEVID: rd_mux = DEV_ID; // RULE_18
			`SIO_IDX_REVID: rd_mux = REV_ID; // RULE_19
			`SIO_IDX_TEST: rd_mux = test_ff;
			default: rd_mux = 8'h00;
		endcase
	end
endfunction
always @(posedge clk or negedge nrst) begin
	if (!nrst) begin
		ioDataOut_ff <= 8'h00;
		ioDataOe_ff <= 1'b0;
	end else begin
		ioDataOe_ff <= ~ctlS2_ff[1] & hitData & cfgMode_ff; // RULE_25
		if (rdStrobe && hitData && cfgMode_ff)
			ioDataOut_ff <= rd_mux(selIndex_ff); // RULE_25
	end
end
// --------------------------------------------------------------------------
// Functional outputs driven from the configuration.
// --------------------------------------------------------------------------
function [3:0] swap01;
	input en;
	input [3:0] sel;
	begin
		if (en)
			swap01 = {sel[3:2], sel[0], sel[1]};
		else
			swap01 = sel;
	end
endfunction
wire ecpOn = extSetup_ff[`SIO_B_ECP_MODE];
wire bothExt = ecpOn & extSetup_ff[`SIO_B_EPP_MODE];
wire [10:0] auxMatch = {auxHi_ff[2] & ecpOn, auxHi_ff[1:0], auxLo_ff}; // RULE_11
wire [10:0] addr11 = {addrS2_ff[10] & ecpOn, addrS2_ff[9:0]}; // RULE_11
wire swap = addrSetup_ff[`SIO_B_SWAP];
wire [3:0] dsSwap = swap01(swap, driveSelIn); // RULE_05
wire [3:0] msSwap = swap01(swap, motorSelIn); // RULE_05
wire [1:0] dsCode = {dsSwap[3] | dsSwap[2], dsSwap[3] | dsSwap[1]};
wire [2:0] u2Mode = serMode_ff[`SIO_F_U2MODE];
// --------------------------------------------------------------------------
// Floppy controller outputs.
// --------------------------------------------------------------------------
always @(posedge clk or negedge nrst) begin
	if (!nrst) begin
		fdcAtSecondary_ff <= 1'b0;
		ideAtSecondary_ff <= 1'b0;
		nonBurstDma_ff <= 1'b0;
		floppyDmaRequest_ff <= 1'b0;
		floppyInterruptRequest_ff <= 1'b0;
		driveSel_ff <= 4'h0;
		motorSel_ff <= 4'h0;
		externalDriveDecoderSel_ff <= 1'b0;
		densityMode_ff <= 2'h0;
	end else begin
		fdcAtSecondary_ff <= addrSetup_ff[`SIO_B_FDC_SEC]; // RULE_02
		ideAtSecondary_ff <= addrSetup_ff[`SIO_B_IDE_SEC]; // RULE_03
		nonBurstDma_ff <= addrSetup_ff[`SIO_B_NONBURST]; // RULE_04
		floppyDmaRequest_ff <= addrSetup_ff[`SIO_B_NONBURST] ? fdcByteDone & fdcDmaReqIn : fdcDmaReqIn; // RULE_04
		floppyInterruptRequest_ff <= addrSetup_ff[`SIO_B_NONBURST] ? fdcByteDone & fdcIrqIn : fdcIrqIn; // RULE_04
		externalDriveDecoderSel_ff <= addrSetup_ff[`SIO_B_EXTDEC]; // RULE_06
		driveSel_ff <= addrSetup_ff[`SIO_B_EXTDEC] ? {2'h0, dsCode} : dsSwap; // RULE_06
		motorSel_ff <= msSwap; // RULE_05
		densityMode_ff <= addrSetup_ff[4:3];
	end
end
// --------------------------------------------------------------------------
// Power management, media polarity and boot drive.
// --------------------------------------------------------------------------
always @(posedge clk or negedge nrst) begin
	if (!nrst) begin
		autoPowerdownEn_ff <= 4'h0;
		mediaId1_ff <= 1'b0;
		mediaId2_ff <= 1'b0;
		bootDrive_ff <= 2'h0;
	end else begin
		autoPowerdownEn_ff <= pwrBoot_ff[`SIO_B_APD_FDC:`SIO_B_APD_PAR]; // RULE_07
		mediaId1_ff <= midS2_ff[0] ^ pwrBoot_ff[`SIO_B_MID1_INV]; // RULE_08
		mediaId2_ff <= midS2_ff[1] ^ pwrBoot_ff[`SIO_B_MID2_INV]; // RULE_08
		bootDrive_ff <= pwrBoot_ff[`SIO_F_BOOT]; // RULE_09
	end
end
// --------------------------------------------------------------------------
// Auxiliary decode and rate table.
// --------------------------------------------------------------------------
always @(posedge clk or negedge nrst) begin
	if (!nrst) begin
		auxAddressDecode_ff <= 1'b0;
		rateTableHighBit_ff <= 2'h0;
		rateTableLowBit_ff <= 2'h0;
	end else begin
		auxAddressDecode_ff <= ~aenS & (addr11 == auxMatch); // RULE_10
		rateTableHighBit_ff <= {1'b0, rateTbl_ff[{rateDrive, 1'b1}]}; // RULE_13
		rateTableLowBit_ff <= {1'b0, rateTbl_ff[{rateDrive, 1'b0}]}; // RULE_13
	end
end
// --------------------------------------------------------------------------
// Serial port modes.
// --------------------------------------------------------------------------
always @(posedge clk or negedge nrst) begin
	if (!nrst) begin
		uartHighSpeed_ff <= 2'h0;
		infraredPulseMode_ff <= 1'b0;
		infraredCarrierMode_ff <= 1'b0;
		serial2HalfDuplex_ff <= 1'b0;
		transmitOutput_ff <= 1'b0;
		serial2Rx_ff <= 1'b0;
	end else begin
		uartHighSpeed_ff <= {serMode_ff[`SIO_B_HS2], serMode_ff[`SIO_B_HS1]}; // RULE_14
		infraredPulseMode_ff <= (u2Mode == `SIO_U2_IRDA); // RULE_15
		infraredCarrierMode_ff <= (u2Mode == `SIO_U2_ASK); // RULE_15
		serial2HalfDuplex_ff <= serMode_ff[`SIO_B_HALFDUP]; // RULE_16
		transmitOutput_ff <= serial2TxIn ^ serMode_ff[`SIO_B_TXINV]; // RULE_17
		serial2Rx_ff <= receiveInput ^ serMode_ff[`SIO_B_RXINV]; // RULE_17
	end
end
// --------------------------------------------------------------------------
// Parallel mode and MIDI baud tick.
// --------------------------------------------------------------------------
// The clock stands in for the 24 MHz reference, so the tick is only exact at that rate.
reg [3:0] midiPre_ff;
reg [3:0] midiPost_ff;
wire midiOn = extSetup_ff[`SIO_B_MIDI1] | extSetup_ff[`SIO_B_MIDI2];
wire preWrap = (midiPre_ff == `SIO_MIDI_PRE_LAST);
always @(posedge clk or negedge nrst) begin
	if (!nrst) begin
		eppViaEcr_ff <= 1'b0;
		midiPre_ff <= 4'h0;
		midiPost_ff <= 4'h0;
		midiBaudTick_ff <= 1'b0;
	end else begin
		eppViaEcr_ff <= bothExt & (ecrMode == `SIO_ECR_EPP); // RULE_21
		midiPre_ff <= (!midiOn || preWrap) ? 4'h0 : midiPre_ff + 4'h1; // RULE_22
		if (midiOn && preWrap)
			midiPost_ff <= midiPost_ff + 4'h1; // RULE_22
		midiBaudTick_ff <= midiOn & preWrap & (midiPost_ff == `SIO_MIDI_POST_LAST); // RULE_22
	end
end
endmodule // sio_cfg_bank
`default_nettype wire

// ==== dv/sio_cfg_monitor.sv ====
`timescale 1ns/10ps
`default_nettype none
// ----
// Pin checks.
// ----
module sio_cfg_monitor (
	input wire logic clk,
	input wire logic nrst,
	input wire logic [10:0] ioAddr,
	input wire logic [7:0] ioDataIn,
	input wire logic ioWrN,
	input wire logic aen,
	input wire logic fdcDmaReqIn,
	input wire logic fdcByteDone,
	input wire logic ioDataOe_ff,
	input wire logic cfgMode_ff,
	input wire logic nonBurstDma_ff,
	input wire logic floppyDmaRequest_ff,
	input wire logic floppyInterruptRequest_ff,
	input wire logic [15:0] driveTypes_ff,
	input wire logic auxAddressDecode_ff,
	input wire logic midiBaudTick_ff
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);
	// The strobe is still held when the mode flag moves, so the key is on the data pins then.
	rst_vals_a: assert property ($rose(nrst) |-> driveTypes_ff == 16'hFFFF && !cfgMode_ff)
		else $error("reset value wrong");
	enter_key_a: assert property ($rose(cfgMode_ff) |-> !ioWrN && ioDataIn == 8'h44)
		else $error("entry without key");
	exit_key_a: assert property ($fell(cfgMode_ff) |-> !ioWrN && ioDataIn == 8'hAA)
		else $error("exit without key");
	read_oe_a: assert property (ioDataOe_ff |-> cfgMode_ff && ioAddr[0] && ioWrN)
		else $error("data drive outside access");
	aux_aen_a: assert property (aen [*5] |-> !auxAddressDecode_ff)
		else $error("decode during dma");
	pulse_gate_a: assert property ((nonBurstDma_ff && !fdcByteDone) [*2] |-> !floppyDmaRequest_ff && !floppyInterruptRequest_ff)
		else $error("request without byte");
	burst_pass_a: assert property ((!nonBurstDma_ff && fdcDmaReqIn) [*2] |-> floppyDmaRequest_ff)
		else $error("burst request lost");
	midi_pulse_a: assert property (midiBaudTick_ff |=> !midiBaudTick_ff [*8])
		else $error("tick too wide");
	cover property ($rose(cfgMode_ff));
	cover property (ioDataOe_ff);
	cover property (auxAddressDecode_ff);
	cover property (midiBaudTick_ff);
endmodule // sio_cfg_monitor
bind sio_cfg_bank sio_cfg_monitor u_mon (.clk, .nrst, .ioAddr, .ioDataIn, .ioWrN, .aen, .fdcDmaReqIn, .fdcByteDone,
	.ioDataOe_ff, .cfgMode_ff, .nonBurstDma_ff, .floppyDmaRequest_ff, .floppyInterruptRequest_ff, .driveTypes_ff,
	.auxAddressDecode_ff, .midiBaudTick_ff);
`default_nettype wire

// ==== dv/sio_host_model.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "sio_cfg_defines.vh"
// ----
// Host bus cycles.
// ----
module sio_host_model (
	input wire logic clk,
	input wire logic [7:0] ioDataOut_ff,
	output logic [10:0] ioAddr,
	output logic [7:0] ioDataIn,
	output logic ioWrN,
	output logic ioRdN,
	output logic aen
);
	logic [7:0] dummy;
	initial begin
		ioAddr = 11'h000;
		ioDataIn = 8'h00;
		ioWrN = 1'b1;
		ioRdN = 1'b1;
		aen = 1'b0;
	end
	// Strobes last eight cycles with eight idle after, well over the synchroniser spacing.
	task automatic io(input logic wr, input logic [10:0] a, input logic [7:0] d, output logic [7:0] r);
		@(posedge clk);
		ioAddr <= a;
		ioDataIn <= d;
		aen <= 1'b0;
		ioWrN <= !wr;
		ioRdN <= wr;
		repeat (8) @(posedge clk);
		r = ioDataOut_ff;
		ioWrN <= 1'b1;
		ioRdN <= 1'b1;
		ioDataIn <= ~d;
		repeat (8) @(posedge clk);
		@(negedge clk);
	endtask
	task automatic cfg_wr(input logic [7:0] x, input logic [7:0] d);
		io(1'b1, `SIO_CFG_PORT_PRI, x, dummy);
		io(1'b1, `SIO_CFG_PORT_PRI + 11'h001, d, dummy);
	endtask
	task automatic cfg_rd(input logic [7:0] x, output logic [7:0] r);
		io(1'b1, `SIO_CFG_PORT_PRI, x, dummy);
		io(1'b0, `SIO_CFG_PORT_PRI + 11'h001, 8'h00, r);
	endtask
	task automatic unlock;
		io(1'b1, `SIO_CFG_PORT_PRI, `SIO_KEY_ENTER, dummy);
		io(1'b1, `SIO_CFG_PORT_PRI, `SIO_KEY_ENTER, dummy);
	endtask
	task automatic probe(input logic [10:0] a, input logic e);
		@(posedge clk);
		ioAddr <= a;
		aen <= e;
		repeat (8) @(posedge clk);
		@(negedge clk);
	endtask
endmodule // sio_host_model
`default_nettype wire

// ==== dv/superio_config_register_bank_tb.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "sio_cfg_defines.vh"
`define CHK(n, e, a) begin samplesChecked++; if ((a) !== (e)) begin nErrors++; $display("Error %s exp %0h got %0h", n, e, a); end end
module superio_config_register_bank_tb;
	logic clk, nrst, cfgAtSecondary, fdcDmaReqIn, fdcIrqIn, fdcByteDone, mediaId1In, mediaId2In, serial2TxIn;
	logic receiveInput, ioWrN, ioRdN, aen, ioDataOe_ff, cfgMode_ff, fdcAtSecondary_ff, ideAtSecondary_ff;
	logic nonBurstDma_ff, floppyDmaRequest_ff, floppyInterruptRequest_ff, externalDriveDecoderSel_ff;
	logic mediaId1_ff, mediaId2_ff, auxAddressDecode_ff, infraredPulseMode_ff, infraredCarrierMode_ff;
	logic serial2HalfDuplex_ff, transmitOutput_ff, serial2Rx_ff, eppViaEcr_ff, midiBaudTick_ff;
	logic [1:0] rateDrive, densityMode_ff, bootDrive_ff, rateTableHighBit_ff, rateTableLowBit_ff, uartHighSpeed_ff;
	logic [2:0] ecrMode;
	logic [3:0] driveSelIn, motorSelIn, driveSel_ff, motorSel_ff, autoPowerdownEn_ff, n;
	logic [7:0] ioDataIn, ioDataOut_ff, parFifoThreshold_ff, q;
	logic [10:0] ioAddr;
	logic [15:0] driveTypes_ff;
	logic [7:0] ix [8] = '{8'h05, 8'h06, 8'h07, 8'h08, 8'h09, 8'h0A, 8'h0B, 8'h0C};
	integer nErrors = 0;
	integer samplesChecked = 0;
	integer cyc = 0;
	integer i;
	localparam logic [10:0] P = `SIO_CFG_PORT_PRI;
	sio_cfg_bank dut (.clk, .nrst, .ioAddr, .ioDataIn, .ioWrN, .ioRdN, .aen, .cfgAtSecondary, .ecrMode,
		.fdcDmaReqIn, .fdcIrqIn, .fdcByteDone, .driveSelIn, .motorSelIn, .mediaId1In, .mediaId2In, .rateDrive,
		.serial2TxIn, .receiveInput, .ioDataOut_ff, .ioDataOe_ff, .cfgMode_ff, .fdcAtSecondary_ff, .ideAtSecondary_ff,
		.nonBurstDma_ff, .floppyDmaRequest_ff, .floppyInterruptRequest_ff, .driveSel_ff, .motorSel_ff,
		.externalDriveDecoderSel_ff, .densityMode_ff, .driveTypes_ff, .autoPowerdownEn_ff, .mediaId1_ff, .mediaId2_ff,
		.bootDrive_ff, .auxAddressDecode_ff, .parFifoThreshold_ff, .rateTableHighBit_ff, .rateTableLowBit_ff,
		.uartHighSpeed_ff, .infraredPulseMode_ff, .infraredCarrierMode_ff, .serial2HalfDuplex_ff, .transmitOutput_ff,
		.serial2Rx_ff, .eppViaEcr_ff, .midiBaudTick_ff);
	sio_host_model u_host (.clk, .ioDataOut_ff, .ioAddr, .ioDataIn, .ioWrN, .ioRdN, .aen);
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	// The whole sequence needs about 2000 cycles; the ceiling leaves room for slow answers.
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			nErrors++;
			stop_test();
		end
	end
	task stop_test;
		$display("checks %0d errors %0d", samplesChecked, nErrors);
		if (nErrors == 0 && samplesChecked > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task t_entry;
		`CHK("types", 16'hFFFF, driveTypes_ff)
		`CHK("apd", 4'h0, autoPowerdownEn_ff)
		`CHK("thr", 8'h00, parFifoThreshold_ff)
		u_host.io(1'b1, P, `SIO_KEY_ENTER, q);
		u_host.io(1'b1, 11'h2F8, 8'h00, q);
		u_host.io(1'b1, P, `SIO_KEY_ENTER, q);
		`CHK("mode", 1'b0, cfgMode_ff)
		u_host.unlock();
		`CHK("mode", 1'b1, cfgMode_ff)
		$display("t_entry done");
	endtask
	task t_regs;
		u_host.cfg_rd(8'h06, q);
		`CHK("r06", 8'hFF, q)
		for (i = 0; i < 8; i++) begin
			u_host.cfg_wr(ix[i], 8'hA5);
			u_host.cfg_rd(ix[i], q);
			`CHK("rw", (ix[i] == 8'h05) ? 8'h25 : (ix[i] == 8'h09) ? 8'h05 : 8'hA5, q)
		end
		`CHK("types", 16'hA5A5, driveTypes_ff)
		u_host.cfg_wr(8'h0D, 8'h00);
		u_host.cfg_rd(8'h0D, q);
		`CHK("id", 8'h5A, q)
		u_host.cfg_rd(8'h0E, q);
		`CHK("rev", 8'h01, q)
		u_host.cfg_rd(8'h10, q);
		`CHK("unmapped", 8'h00, q)
		u_host.cfg_wr(8'h0F, 8'h00);
		u_host.cfg_rd(8'h0F, q);
		`CHK("test", 8'h00, q)
		$display("t_regs done");
	endtask
	task t_fdc;
		u_host.cfg_wr(8'h05, 8'h67);
		`CHK("ab", 4'hF, {fdcAtSecondary_ff, ideAtSecondary_ff, nonBurstDma_ff, externalDriveDecoderSel_ff})
		driveSelIn <= 4'h1;
		motorSelIn <= 4'h2;
		u_host.cfg_wr(8'h05, 8'h20);
		`CHK("swap", 8'h21, {driveSel_ff, motorSel_ff})
		u_host.cfg_wr(8'h05, 8'h04);
		fdcDmaReqIn <= 1'b1;
		fdcIrqIn <= 1'b1;
		repeat (4) @(posedge clk);
		fdcByteDone <= 1'b1;
		@(posedge clk);
		fdcByteDone <= 1'b0;
		n = 4'h0;
		for (i = 0; i < 8; i++) begin
			@(negedge clk);
			n = n + floppyDmaRequest_ff;
		end
		`CHK("pulses", 4'h1, n)
		u_host.cfg_wr(8'h05, 8'h00);
		`CHK("burst", 2'h3, {floppyDmaRequest_ff, fdcAtSecondary_ff == 1'b0})
		$display("t_fdc done");
	endtask
	task t_pwr;
		mediaId1In <= 1'b1;
		mediaId2In <= 1'b1;
		for (i = 0; i < 4; i++) begin
			u_host.cfg_wr(8'h07, 8'h98 | i[7:0]);
			`CHK("boot", i[1:0], bootDrive_ff)
		end
		`CHK("apd", 4'h9, autoPowerdownEn_ff)
		`CHK("media", 2'h1, {mediaId1_ff, mediaId2_ff})
		@(posedge clk);
		rateDrive <= 2'h2;
		repeat (2) @(negedge clk);
		`CHK("rate", 4'h4, {rateTableHighBit_ff, rateTableLowBit_ff})
		$display("t_pwr done");
	endtask
	task t_aux;
		u_host.cfg_wr(8'h08, 8'h34);
		u_host.cfg_wr(8'h09, 8'h05);
		u_host.probe(11'h134, 1'b0);
		`CHK("aux", 1'b1, auxAddressDecode_ff)
		u_host.probe(11'h134, 1'b1);
		`CHK("aux", 1'b0, auxAddressDecode_ff)
		u_host.cfg_wr(8'h04, 8'h02);
		u_host.probe(11'h534, 1'b0);
		`CHK("aux", 1'b1, auxAddressDecode_ff)
		u_host.probe(11'h134, 1'b0);
		`CHK("aux", 1'b0, auxAddressDecode_ff)
		$display("t_aux done");
	endtask
	task t_serial;
		serial2TxIn <= 1'b1;
		receiveInput <= 1'b1;
		for (i = 0; i < 4; i++) begin
			u_host.cfg_wr(8'h0C, {2'b11, i[2:0], 3'b111});
			`CHK("ir", {i == 1, i == 2}, {infraredPulseMode_ff, infraredCarrierMode_ff})
		end
		`CHK("hs", 2'h3, uartHighSpeed_ff)
		`CHK("dup", 1'b1, serial2HalfDuplex_ff)
		`CHK("pol", 2'h0, {transmitOutput_ff, serial2Rx_ff})
		$display("t_serial done");
	endtask
	task t_ext;
		u_host.cfg_wr(8'h04, 8'h10);
		for (i = 0; i < 400 && midiBaudTick_ff !== 1'b1; i++)
			@(negedge clk);
		for (i = 1; i < 400; i++) begin
			@(negedge clk);
			if (midiBaudTick_ff === 1'b1)
				break;
		end
		`CHK("tick", 192, i)
		u_host.cfg_wr(8'h04, 8'h03);
		ecrMode <= 3'h4;
		repeat (4) @(negedge clk);
		`CHK("epp", 1'b1, eppViaEcr_ff)
		ecrMode <= 3'h0;
		repeat (4) @(negedge clk);
		`CHK("spp", 1'b0, eppViaEcr_ff)
		$display("t_ext done");
	endtask
	task t_exit;
		u_host.io(1'b1, P, 8'h0A, q);
		u_host.io(1'b1, P, `SIO_KEY_EXIT, q);
		`CHK("mode", 1'b0, cfgMode_ff)
		u_host.io(1'b1, P + 11'h001, 8'h55, q);
		`CHK("thr", 8'hA5, parFifoThreshold_ff)
		$display("t_exit done");
	endtask
	initial begin
		{cfgAtSecondary, fdcDmaReqIn, fdcIrqIn, fdcByteDone, mediaId1In, mediaId2In, serial2TxIn, receiveInput} = 8'h00;
		{driveSelIn, motorSelIn, rateDrive, ecrMode} = 13'h0000;
		nrst = 1'b0;
		repeat (10) @(posedge clk);
		nrst <= 1'b1;
		@(negedge clk);
		t_entry();
		t_regs();
		t_fdc();
		t_pwr();
		t_aux();
		t_serial();
		t_ext();
		t_exit();
		stop_test();
	end
endmodule // superio_config_register_bank_tb
`default_nettype wire
